// ### panel_status.v
/*
 * Operator-panel status and control: trim-knob value words with range
 * clamping on program load, live or confirm-on-enter knob editing,
 * confirm/cancel key latches, user screen flag, backlight and contrast.
 * Assumes panel key and mode pins are asynchronous; program port and
 * loader signals run on sys_clk.
 */
`timescale 1ns/100ps
`include "panel_defs.vh"

module panel_status #(
    parameter [32:0] BL_TIMEOUT_CYC = `BL_TIMEOUT_CYC
) (
    input wire sys_clk,
    input wire rstn,
    input wire key_up,
    input wire key_down,
    input wire key_ok,
    input wire key_esc,
    input wire knob_select,
    input wire user_display_mode,
    input wire knob_hw_fault,
    input wire menu_live_value,
    input wire menu_live_write,
    input wire prog_wr,
    input wire prog_rd,
    input wire [2:0] prog_idx,
    input wire [15:0] prog_wdata,
    output reg [15:0] prog_rdata_q,
    input wire tool_live_wr,
    input wire tool_live_value,
    input wire load_start,
    input wire [15:0] trim_lower_bound,
    input wire [15:0] trim_upper_bound,
    output reg load_done_q,
    input wire instr_check,
    input wire disp_with_input,
    input wire [1:0] line4_first_kind,
    input wire line4_second_used,
    input wire [5:0] src_immediate,
    input wire [5:0] src_nonzero,
    output reg operand_reject_q,
    output reg backlight_on_q,
    output reg [15:0] contrast_out_q,
    output reg screen_user_mode_q
);

    // clamp a sign-extended value to a signed lower/upper pair
    function [15:0] clamp_val;
        input [16:0] t;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if ($signed(t) < $signed({lo[15], lo}))
                clamp_val = lo;
            else if ($signed(t) > $signed({hi[15], hi}))
                clamp_val = hi;
            else
                clamp_val = t[15:0];
        end
    endfunction

    function out_of_range;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            out_of_range = ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
        end
    endfunction

    // one knob step up or down, held inside the bounds
    function [15:0] trim_step;
        input [15:0] v;
        input up;
        input [15:0] lo;
        input [15:0] hi;
        reg [16:0] t;
        begin
            t = up ? ({v[15], v} + 17'h00001) : ({v[15], v} - 17'h00001);
            trim_step = clamp_val(t, lo, hi);
        end
    endfunction

    // pin synchronisers, third stage only for edge detection
    wire [`PIN_W-1:0] pin_raw;
    reg [`PIN_W-1:0] sync1_q;
    reg [`PIN_W-1:0] sync2_q;
    reg [`PIN_W-1:0] prev_q;
    wire [`PIN_W-1:0] rise;

    assign pin_raw = {menu_live_write, menu_live_value, knob_hw_fault, user_display_mode,
                      knob_select, key_esc, key_ok, key_down, key_up};

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= {`PIN_W{1'h0}};
            sync2_q <= {`PIN_W{1'h0}};
            prev_q <= {`PIN_W{1'h0}};
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // edge stage resets low like the idle pins, so reset gives no false press
    assign rise = sync2_q & ~prev_q;

    wire udm = sync2_q[`PIN_UDM];
    wire sel = sync2_q[`PIN_SEL];
    wire up_p = rise[`PIN_UP];
    wire dn_p = rise[`PIN_DOWN];
    wire ok_p = rise[`PIN_OK];
    wire esc_p = rise[`PIN_ESC];
    wire any_key = up_p | dn_p | ok_p | esc_p;
    wire step_p = up_p ^ dn_p;
    wire wr_ctrl = prog_wr && (prog_idx == `IDX_CTRL);
    wire wr_contrast = prog_wr && (prog_idx == `IDX_CONTRAST);

    // control bits and key latches
    reg live_q;
    reg confirm_q;
    reg cancel_q;
    reg bl_switch_q;
    reg bl_hold_q;
    reg range_fault_q;
    reg [15:0] fault_code_q;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            live_q <= `RST_LIVE;
            confirm_q <= 1'h0;
            cancel_q <= 1'h0;
            bl_switch_q <= `RST_BL_SWITCH;
            bl_hold_q <= `RST_BL_HOLD;
        end else begin
            if (wr_ctrl) begin
                live_q <= prog_wdata[`BIT_LIVE];
                bl_switch_q <= prog_wdata[`BIT_BL_SWITCH];
                bl_hold_q <= prog_wdata[`BIT_BL_HOLD];
            end else if (rise[`PIN_MWR]) begin
                live_q <= sync2_q[`PIN_MLIVE];
            end else if (tool_live_wr) begin
                live_q <= tool_live_value;
            end
            // press in user display mode sets; set wins over program clear
            if (ok_p && udm)
                confirm_q <= 1'h1;
            else if (wr_ctrl)
                confirm_q <= prog_wdata[`BIT_CONFIRM];
            if (esc_p && udm)
                cancel_q <= 1'h1;
            else if (wr_ctrl)
                cancel_q <= prog_wdata[`BIT_CANCEL];
        end
    end

    // trim knob values, pending edits and bounds
    reg [15:0] knob0_q;
    reg [15:0] knob1_q;
    reg [15:0] pend0_q;
    reg [15:0] pend1_q;
    reg [15:0] lower_q;
    reg [15:0] upper_q;
    wire edit_now = step_p && !udm;
    wire [15:0] knob0_fit;
    wire [15:0] knob1_fit;

    // value and pending copy take the same clamp on load
    assign knob0_fit = clamp_val({knob0_q[15], knob0_q}, trim_lower_bound, trim_upper_bound);
    assign knob1_fit = clamp_val({knob1_q[15], knob1_q}, trim_lower_bound, trim_upper_bound);

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            knob0_q <= `RST_KNOB;
            knob1_q <= `RST_KNOB;
            pend0_q <= `RST_KNOB;
            pend1_q <= `RST_KNOB;
            lower_q <= `RST_LOWER;
            upper_q <= `RST_UPPER;
            range_fault_q <= 1'h0;
            load_done_q <= 1'h0;
        end else begin
            load_done_q <= load_start;
            if (load_start) begin
                // load wins over key edits arriving in the same cycle
                lower_q <= trim_lower_bound;
                upper_q <= trim_upper_bound;
                knob0_q <= knob0_fit;
                knob1_q <= knob1_fit;
                pend0_q <= knob0_fit;
                pend1_q <= knob1_fit;
                range_fault_q <= out_of_range(knob0_q, trim_lower_bound, trim_upper_bound)
                              || out_of_range(knob1_q, trim_lower_bound,
                                              trim_upper_bound);
            end else if (live_q) begin
                // pending copies follow, so a switch to confirm mode starts clean
                if (edit_now && !sel)
                    knob0_q <= trim_step(knob0_q, up_p, lower_q, upper_q);
                if (edit_now && sel)
                    knob1_q <= trim_step(knob1_q, up_p, lower_q, upper_q);
                pend0_q <= knob0_q;
                pend1_q <= knob1_q;
            end else if (ok_p && !udm) begin
                knob0_q <= pend0_q;
                knob1_q <= pend1_q;
            end else if (esc_p && !udm) begin
                pend0_q <= knob0_q;
                pend1_q <= knob1_q;
            end else if (edit_now) begin
                if (!sel)
                    pend0_q <= trim_step(pend0_q, up_p, lower_q, upper_q);
                else
                    pend1_q <= trim_step(pend1_q, up_p, lower_q, upper_q);
            end
        end
    end

    // fault code follows the range flag and the knob hardware pin
    // range fault outranks the hardware fault
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            fault_code_q <= `FAULT_NONE;
        else if (range_fault_q)
            fault_code_q <= `FAULT_RANGE;
        else if (sync2_q[`PIN_HWF])
            fault_code_q <= `FAULT_KNOB_HW;
        else
            fault_code_q <= `FAULT_NONE;
    end

    // contrast, clamped on write
    // negative or oversized writes land on the nearer limit
    reg [15:0] contrast_q;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            contrast_q <= `RST_CONTRAST;
        else if (wr_contrast)
            contrast_q <= clamp_val({prog_wdata[15], prog_wdata}, `CONTRAST_MIN,
                                    `CONTRAST_MAX);
    end

    // backlight timeout counter
    reg [32:0] bl_cnt_q;
    reg bl_switch_prev_q;
    wire bl_restart = any_key || (bl_switch_q && !bl_switch_prev_q);
    wire bl_running = (bl_cnt_q != 33'h000000000);

    // switch history resets low, so the timer starts once after reset
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bl_cnt_q <= 33'h000000000;
            bl_switch_prev_q <= 1'h0;
        end else begin
            bl_switch_prev_q <= bl_switch_q;
            if (bl_restart)
                bl_cnt_q <= BL_TIMEOUT_CYC;
            else if (bl_running)
                bl_cnt_q <= bl_cnt_q - 33'h000000001;
        end
    end

    // panel-facing outputs
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            backlight_on_q <= 1'h0;
            contrast_out_q <= `RST_CONTRAST;
            screen_user_mode_q <= 1'h0;
        end else begin
            backlight_on_q <= bl_switch_q
                && (bl_hold_q || bl_restart || bl_running);
            contrast_out_q <= contrast_q;
            screen_user_mode_q <= udm;
        end
    end

    // instruction operand check
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            operand_reject_q <= 1'h0;
        else if (instr_check) begin
            if (disp_with_input)
                operand_reject_q <= (line4_first_kind == `KIND_OTHER)
                                 || line4_second_used;
            else
                operand_reject_q <= |(src_immediate & src_nonzero);
        end
    end

    // program read port
    reg [15:0] ctrl_word;

    always @* begin
        ctrl_word = 16'h0000;
        ctrl_word[`BIT_LIVE] = live_q;
        ctrl_word[`BIT_CONFIRM] = confirm_q;
        ctrl_word[`BIT_CANCEL] = cancel_q;
        ctrl_word[`BIT_BL_SWITCH] = bl_switch_q;
        ctrl_word[`BIT_BL_HOLD] = bl_hold_q;
        ctrl_word[`BIT_SCREEN] = udm;
        ctrl_word[`BIT_RANGE_FAULT] = range_fault_q;
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            prog_rdata_q <= 16'h0000;
        else if (prog_rd) begin
            case (prog_idx)
                `IDX_CTRL: prog_rdata_q <= ctrl_word;
                `IDX_CONTRAST: prog_rdata_q <= contrast_q;
                `IDX_KNOB0: prog_rdata_q <= knob0_q;
                `IDX_KNOB1: prog_rdata_q <= knob1_q;
                `IDX_LOWER: prog_rdata_q <= lower_q;
                `IDX_UPPER: prog_rdata_q <= upper_q;
                `IDX_FAULT: prog_rdata_q <= fault_code_q;
                // index 7 reads as zero
                default: prog_rdata_q <= 16'h0000;
            endcase
        end
    end

endmodule

// ### panel_defs.vh
/*
 * Constants of the operator-panel status and control block: element
 * indices, control bit positions, reset values, limits and timing counts.
 * Assumes inclusion by bare name from the panel design file.
 */
`ifndef PANEL_DEFS_VH
`define PANEL_DEFS_VH

// element indices on the program data port
`define IDX_CTRL 3'h0
`define IDX_CONTRAST 3'h1
`define IDX_KNOB0 3'h2
`define IDX_KNOB1 3'h3
`define IDX_LOWER 3'h4
`define IDX_UPPER 3'h5
`define IDX_FAULT 3'h6

// bit positions of the control element
`define BIT_LIVE 0
`define BIT_CONFIRM 1
`define BIT_CANCEL 2
`define BIT_BL_SWITCH 3
`define BIT_BL_HOLD 4
`define BIT_SCREEN 5
`define BIT_RANGE_FAULT 6

// reset values
`define RST_LIVE 1'h0
`define RST_BL_SWITCH 1'h1
`define RST_BL_HOLD 1'h0
`define RST_CONTRAST 16'h0019
`define RST_KNOB 16'h0000
`define RST_LOWER 16'h0000
`define RST_UPPER 16'h00FA

// contrast limits
`define CONTRAST_MIN 16'h000F
`define CONTRAST_MAX 16'h0023

// panel fault codes
`define FAULT_NONE 16'h0000
`define FAULT_KNOB_HW 16'h0001
`define FAULT_RANGE 16'h0002

// destination kinds for the fourth-line input operand
`define KIND_BIT 2'h0
`define KIND_INT 2'h1
`define KIND_LONG 2'h2
`define KIND_OTHER 2'h3

// synchronised panel pin positions
`define PIN_UP 0
`define PIN_DOWN 1
`define PIN_OK 2
`define PIN_ESC 3
`define PIN_SEL 4
`define PIN_UDM 5
`define PIN_HWF 6
`define PIN_MLIVE 7
`define PIN_MWR 8
`define PIN_W 9

// backlight timeout: seconds and clock rate, cycles derived
`define BL_TIMEOUT_S 33'h00000001E
`define CLK_HZ 33'h00BEBC200
`define BL_TIMEOUT_CYC (`BL_TIMEOUT_S * `CLK_HZ)

`endif

// ### panel_status_sva.sv
/*
 * Port assertions for the panel status block.
 * Assumes a bind onto panel_status; one clock domain.
 */
`timescale 1ns/100ps
module panel_status_sva (
    input wire sys_clk,
    input wire rstn,
    input wire user_display_mode,
    input wire prog_wr,
    input wire [2:0] prog_idx,
    input wire [15:0] prog_wdata,
    input wire load_start,
    input wire load_done_q,
    input wire instr_check,
    input wire disp_with_input,
    input wire [1:0] line4_first_kind,
    input wire line4_second_used,
    input wire operand_reject_q,
    input wire [15:0] contrast_out_q,
    input wire screen_user_mode_q
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    AST_LOAD_DONE: assert property (load_start |=> load_done_q)
        else $error("load done missing");
    AST_DONE_PULSE: assert property (!load_start |=> !load_done_q)
        else $error("load done without load");
    AST_CONTRAST_LEVEL_RANGE: assert property (contrast_out_q >= 16'h000F && contrast_out_q <= 16'h0023)
        else $error("contrast out of range");
    AST_CONTRAST_LEVEL_HIGH: assert property (prog_wr && prog_idx == 3'h1 && $signed(prog_wdata) > 35
        |-> ##2 contrast_out_q == 16'h0023) else $error("contrast not clamped");
    AST_SCREEN_ON: assert property ($rose(user_display_mode) |-> ##[1:5] screen_user_mode_q)
        else $error("screen flag late");
    AST_SCREEN_OFF: assert property ($fell(user_display_mode) |-> ##[1:5] !screen_user_mode_q)
        else $error("screen flag stuck");
    AST_OP_WITH: assert property (instr_check && disp_with_input
        && (line4_first_kind == 2'h3 || line4_second_used) |=> operand_reject_q)
        else $error("bad operand accepted");
    AST_OP_HOLD: assert property (!instr_check |=> $stable(operand_reject_q))
        else $error("reject flag moved");
endmodule

// ### panel_model.sv
/*
 * Keypad, knob selector and panel-mode model.
 * Assumes its tasks are called from the sys_clk domain.
 */
`timescale 1ns/100ps
module panel_model (
    input wire sys_clk,
    output logic [3:0] keys,
    output logic knob_select,
    output logic user_display_mode,
    output logic knob_hw_fault,
    output logic menu_live_value,
    output logic menu_live_write
);
    initial begin
        keys = 4'h0;
        {knob_select, user_display_mode, knob_hw_fault} = 3'h0;
        {menu_live_value, menu_live_write} = 2'h0;
    end
    // held long enough to pass the pin synchroniser
    task automatic press(input int k);
        @(posedge sys_clk) #1 keys[k] = 1'h1;
        repeat (4) @(posedge sys_clk);
        #1 keys[k] = 1'h0;
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic menu_live(input logic v);
        @(posedge sys_clk) #1 menu_live_value = v;
        menu_live_write = 1'h1;
        repeat (4) @(posedge sys_clk);
        #1 menu_live_write = 1'h0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic mode(input logic s, input logic u, input logic f);
        @(posedge sys_clk) #1 {knob_select, user_display_mode, knob_hw_fault} = {s, u, f};
        repeat (5) @(posedge sys_clk);
    endtask
endmodule

// ### testbench.sv
/*
 * Self-checking bench for panel_status over its program port.
 * Assumes panel_model and panel_status_sva are compiled first.
 */
`timescale 1ns/100ps
`include "panel_defs.vh"
module testbench;
    logic sys_clk, rstn, prog_wr, prog_rd, tool_live_wr, tool_live_value, load_start;
    logic instr_check, disp_with_input, line4_second_used;
    logic [1:0] line4_first_kind;
    logic [2:0] prog_idx;
    logic [5:0] src_immediate, src_nonzero;
    logic [15:0] prog_wdata, trim_lower_bound, trim_upper_bound;
    wire [3:0] keys;
    wire knob_select, user_display_mode, knob_hw_fault, menu_live_value, menu_live_write;
    wire [15:0] prog_rdata_q, contrast_out_q;
    wire load_done_q, operand_reject_q, backlight_on_q, screen_user_mode_q;
    wire key_up = keys[`PIN_UP];
    wire key_down = keys[`PIN_DOWN];
    wire key_ok = keys[`PIN_OK];
    wire key_esc = keys[`PIN_ESC];
    int fails, n_compared;
    panel_status #(.BL_TIMEOUT_CYC(33'h32)) panel_status_inst (
        .sys_clk(sys_clk), .rstn(rstn), .key_up(key_up), .key_down(key_down),
        .key_ok(key_ok), .key_esc(key_esc), .knob_select(knob_select),
        .user_display_mode(user_display_mode), .knob_hw_fault(knob_hw_fault),
        .menu_live_value(menu_live_value), .menu_live_write(menu_live_write),
        .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_idx(prog_idx), .prog_wdata(prog_wdata),
        .prog_rdata_q(prog_rdata_q), .tool_live_wr(tool_live_wr),
        .tool_live_value(tool_live_value), .load_start(load_start),
        .trim_lower_bound(trim_lower_bound), .trim_upper_bound(trim_upper_bound),
        .load_done_q(load_done_q), .instr_check(instr_check),
        .disp_with_input(disp_with_input), .line4_first_kind(line4_first_kind),
        .line4_second_used(line4_second_used), .src_immediate(src_immediate),
        .src_nonzero(src_nonzero), .operand_reject_q(operand_reject_q),
        .backlight_on_q(backlight_on_q), .contrast_out_q(contrast_out_q),
        .screen_user_mode_q(screen_user_mode_q));
    panel_model panel_model_inst (.sys_clk(sys_clk), .keys(keys), .knob_select(knob_select),
        .user_display_mode(user_display_mode), .knob_hw_fault(knob_hw_fault),
        .menu_live_value(menu_live_value), .menu_live_write(menu_live_write));
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] i, input logic [15:0] d);
        @(posedge sys_clk) #1 prog_wr = 1'h1;
        prog_idx = i;
        prog_wdata = d;
        @(posedge sys_clk) #1 prog_wr = 1'h0;
    endtask
    task automatic rd(input logic [2:0] i, input logic [15:0] exp);
        @(posedge sys_clk) #1 prog_rd = 1'h1;
        prog_idx = i;
        @(posedge sys_clk) #1 prog_rd = 1'h0;
        check_word(prog_rdata_q, exp);
    endtask
    task automatic bl(input logic e);
        repeat (2) @(posedge sys_clk);
        #1 check_word({15'h0, backlight_on_q}, {15'h0, e});
    endtask
    task automatic load(input logic [15:0] l, input logic [15:0] h);
        @(posedge sys_clk) #1 load_start = 1'h1;
        {trim_lower_bound, trim_upper_bound} = {l, h};
        @(posedge sys_clk) #1 load_start = 1'h0;
        check_word({15'h0, load_done_q}, 16'h0001);
    endtask
    task automatic op(input logic d, input logic [1:0] k, input logic s,
                      input logic [5:0] n, input logic e);
        @(posedge sys_clk) #1 instr_check = 1'h1;
        {disp_with_input, line4_first_kind, line4_second_used} = {d, k, s};
        {src_immediate, src_nonzero} = {6'h3B, n};
        @(posedge sys_clk) #1 instr_check = 1'h0;
        check_word({15'h0, operand_reject_q}, {15'h0, e});
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        $display("CHECK FAILED %0t watchdog", $time);
        final_report;
    end
    initial begin
        {rstn, prog_wr, prog_rd, tool_live_wr, tool_live_value, load_start} = 6'h0;
        {instr_check, disp_with_input, line4_second_used, line4_first_kind} = 5'h0;
        {prog_idx, src_immediate, src_nonzero, prog_wdata} = 31'h0;
        {trim_lower_bound, trim_upper_bound} = 32'h0;
        repeat (5) @(posedge sys_clk);
        #1 rstn = 1'h1;
        rd(`IDX_CTRL, 16'h0008);
        rd(`IDX_CONTRAST, `RST_CONTRAST);
        rd(`IDX_UPPER, `RST_UPPER);
        rd(`IDX_FAULT, `FAULT_NONE);
        bl(1'h1);
        repeat (50) @(posedge sys_clk);
        bl(1'h0);
        wr(`IDX_CONTRAST, 16'h0064);
        rd(`IDX_CONTRAST, `CONTRAST_MAX);
        wr(`IDX_CONTRAST, 16'hFFF6);
        rd(`IDX_CONTRAST, `CONTRAST_MIN);
        wr(`IDX_CONTRAST, 16'h0014);
        @(posedge sys_clk) #1 check_word(contrast_out_q, 16'h0014);
        wr(`IDX_KNOB0, 16'h0033);
        rd(`IDX_KNOB0, 16'h0000);
        done("reset_contrast");
        panel_model_inst.press(`PIN_UP);
        rd(`IDX_KNOB0, 16'h0000);
        panel_model_inst.press(`PIN_OK);
        rd(`IDX_KNOB0, 16'h0001);
        panel_model_inst.press(`PIN_UP);
        panel_model_inst.press(`PIN_ESC);
        rd(`IDX_KNOB0, 16'h0001);
        wr(`IDX_CTRL, 16'h0009);
        rd(`IDX_CTRL, 16'h0009);
        panel_model_inst.press(`PIN_UP);
        rd(`IDX_KNOB0, 16'h0002);
        panel_model_inst.press(`PIN_UP);
        panel_model_inst.press(`PIN_DOWN);
        rd(`IDX_KNOB0, 16'h0002);
        wr(`IDX_CTRL, 16'h0008);
        panel_model_inst.menu_live(1'h1);
        rd(`IDX_CTRL, 16'h0009);
        @(posedge sys_clk) #1 tool_live_wr = 1'h1;
        @(posedge sys_clk) #1 tool_live_wr = 1'h0;
        rd(`IDX_CTRL, 16'h0008);
        done("knob_edit");
        panel_model_inst.mode(1'h0, 1'h1, 1'h0);
        #1 check_word({15'h0, screen_user_mode_q}, 16'h0001);
        panel_model_inst.press(`PIN_OK);
        panel_model_inst.press(`PIN_ESC);
        rd(`IDX_CTRL, 16'h002E);
        wr(`IDX_CTRL, 16'h0008);
        rd(`IDX_CTRL, 16'h0028);
        panel_model_inst.mode(1'h0, 1'h0, 1'h0);
        panel_model_inst.press(`PIN_ESC);
        rd(`IDX_CTRL, 16'h0008);
        done("user_mode");
        load(16'h000A, 16'h0014);
        rd(`IDX_KNOB1, 16'h000A);
        rd(`IDX_CTRL, 16'h0048);
        rd(`IDX_FAULT, `FAULT_RANGE);
        load(16'h00C8, 16'h0032);
        rd(`IDX_KNOB0, 16'h00C8);
        load(16'h0000, 16'h00FA);
        rd(`IDX_CTRL, 16'h0008);
        panel_model_inst.mode(1'h0, 1'h0, 1'h1);
        rd(`IDX_FAULT, `FAULT_KNOB_HW);
        panel_model_inst.mode(1'h1, 1'h0, 1'h0);
        panel_model_inst.press(`PIN_UP);
        panel_model_inst.press(`PIN_OK);
        rd(`IDX_KNOB1, 16'h00C9);
        rd(`IDX_KNOB0, 16'h00C8);
        done("load");
        repeat (50) @(posedge sys_clk);
        panel_model_inst.press(`PIN_UP);
        bl(1'h1);
        repeat (50) @(posedge sys_clk);
        bl(1'h0);
        wr(`IDX_CTRL, 16'h0018);
        bl(1'h1);
        wr(`IDX_CTRL, 16'h0010);
        bl(1'h0);
        done("backlight");
        for (int k = 0; k < 4; k++)
            op(1'h1, k[1:0], 1'h0, 6'h00, k == 3);
        op(1'h1, `KIND_BIT, 1'h1, 6'h00, 1'h1);
        op(1'h0, `KIND_OTHER, 1'h1, 6'h08, 1'h1);
        op(1'h0, `KIND_OTHER, 1'h1, 6'h04, 1'h0);
        done("operands");
        final_report;
    end
endmodule
bind panel_status panel_status_sva panel_status_sva_inst (.sys_clk(sys_clk), .rstn(rstn),
    .user_display_mode(user_display_mode), .prog_wr(prog_wr), .prog_idx(prog_idx),
    .prog_wdata(prog_wdata), .load_start(load_start), .load_done_q(load_done_q),
    .instr_check(instr_check), .disp_with_input(disp_with_input),
    .line4_first_kind(line4_first_kind), .line4_second_used(line4_second_used),
    .operand_reject_q(operand_reject_q), .contrast_out_q(contrast_out_q),
    .screen_user_mode_q(screen_user_mode_q));
